// ### tb/tb_tc_channel.sv
// Purpose: directed bench for the timer channel
// Assumes: single slave, so hready is the slave's own hreadyout
// Notes: io_b input held low; overflow run takes about 65k cycles
`timescale 1ns/1ps
module tb_tc_channel;
  logic i_clk_sys, i_nrst, i_hsel, i_hwrite, i_hready, i_count_en;
  logic i_timer_io_a;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
  logic [1:0] i_htrans;
  logic o_hreadyout, o_hresp, o_irq, io_a, io_a_oen, io_b, io_b_oen;
  int fails, n_compared;
  assign i_hready = o_hreadyout;
  tc_channel u_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_count_en(i_count_en), .i_timer_io_a(i_timer_io_a),
    .o_timer_io_a(io_a), .o_timer_io_a_oen(io_a_oen),
    .i_timer_io_b(1'b0), .o_timer_io_b(io_b),
    .o_timer_io_b_oen(io_b_oen), .o_irq(o_irq));
  initial begin
    i_clk_sys = 0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  // waits for hready; a hung slave ends the run
  task automatic step();
    int k;
    k = 0;
    @(posedge i_clk_sys);
    while (o_hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        fails++;
        stop_test();
      end
      @(posedge i_clk_sys);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    i_hsel <= 1;
    i_htrans <= 2'h2;
    i_haddr <= {24'h0, a};
    i_hwrite <= w;
    step();
    i_hsel <= 0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    step();
    rd = o_hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_clk_sys) i_count_en <= 1;
      @(posedge i_clk_sys) i_count_en <= 0;
    end
  endtask
  // pin goes through a synchroniser and an edge stage
  task automatic pin(input logic v);
    @(posedge i_clk_sys) i_timer_io_a <= v;
    repeat (6) @(posedge i_clk_sys);
  endtask
  task automatic wait_irq(input logic v);
    int k;
    for (k = 0; k < 30 && o_irq !== v; k++) @(posedge i_clk_sys);
    chk({31'h0, o_irq}, {31'h0, v});
  endtask
  task automatic t_regs();
    rdc(8'h2C, 32'h0);
    rdc(8'h20, 32'h0);
    wr(8'h1C, 32'h1234);
    rdc(8'h1C, 32'h1234);
    wr(8'h14, 32'h55);
    rdc(8'h14, 32'h0);
    rdc(8'h30, 32'h0);
    chk({31'h0, o_hresp}, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_irq();
    wr(8'h24, 32'h81);
    rdc(8'h2C, 32'h81);
    wr(8'h28, 32'h01);
    rdc(8'h2C, 32'h80);
    wr(8'h04, 32'h0000_0500);
    pin(1);
    wait_irq(1);
    rdc(8'h20, 32'h0003_0080);
    rdc(8'h20, 32'h0003_0000);
    wait_irq(0);
    pin(0);
    wr(8'h28, 32'hFF);
    rdc(8'h2C, 32'h0);
    wr(8'h00, 32'h2);
    rdc(8'h20, 32'h0);
    $display("test irq done");
  endtask
  task automatic t_capture();
    wr(8'h04, 32'h0009_0000);
    wr(8'h00, 32'h1);
    tick(5);
    rdc(8'h10, 32'h5);
    pin(1);
    pin(0);
    pin(1);
    rdc(8'h20, 32'h0003_0062);
    rdc(8'h14, 32'h5);
    rdc(8'h18, 32'h5);
    $display("test capture done");
  endtask
  task automatic t_wave();
    wr(8'h04, 32'h0000_8000);
    wr(8'h14, 32'h7);
    wr(8'h18, 32'h6);
    wr(8'h1C, 32'h8);
    rdc(8'h14, 32'h7);
    rdc(8'h20, 32'h0001_0000);
    tick(3);
    rdc(8'h20, 32'h0005_001C);
    chk({31'h0, io_a_oen}, 32'h0);
    @(posedge i_clk_sys) i_count_en <= 1;
    repeat (65540) @(posedge i_clk_sys);
    i_count_en <= 0;
    xfer(8'h20, 1'b0, 32'h0);
    chk(rd & 32'h1, 32'h1);
    xfer(8'h20, 1'b0, 32'h0);
    chk(rd & 32'h1, 32'h0);
    $display("test wave done");
  endtask
  initial begin
    fails = 0;
    n_compared = 0;
    i_nrst = 0;
    i_hsel = 0;
    i_haddr = 0;
    i_htrans = 0;
    i_hwrite = 0;
    i_hwdata = 0;
    i_count_en = 0;
    i_timer_io_a = 0;
    repeat (8) @(posedge i_clk_sys);
    i_nrst <= 1;
    t_regs();
    t_irq();
    t_capture();
    t_wave();
    stop_test();
  end
endmodule

// ### tb/tc_channel_sva.sv
// Purpose: port-level checks for the timer channel
// Assumes: zero-wait AHB-Lite slave, read data follows the address edge
// Notes: sees only the top module ports
`timescale 1ns/1ps
module tc_channel_sva (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_timer_io_a,
  input wire logic o_timer_io_a_oen,
  input wire logic o_timer_io_b,
  input wire logic o_timer_io_b_oen,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  sequence s_take(logic [7:0] a, logic w);
    i_hsel && i_htrans[1] && i_hready && i_hwrite == w && i_haddr[7:0] == a;
  endsequence
  sequence s_read(logic [7:0] a);
    s_take(a, 1'b0);
  endsequence
  property p_cnt_hi;
    s_read(8'h10) |=> o_hrdata[31:16] == 16'h0000;
  endproperty
  property p_cmp_hi;
    s_read(8'h1C) |=> o_hrdata[31:16] == 16'h0000;
  endproperty
  property p_sr_hi;
    s_read(8'h20) |=> o_hrdata[31:19] == 13'h0 && o_hrdata[15:8] == 8'h00;
  endproperty
  property p_mask_hi;
    s_read(8'h2C) |=> o_hrdata[31:8] == 24'h000000;
  endproperty
  property p_mir_a;
    s_read(8'h20) ##0 !o_timer_io_a_oen |=> o_hrdata[17] == $past(o_timer_io_a);
  endproperty
  property p_mir_b;
    s_read(8'h20) ##0 !o_timer_io_b_oen |=> o_hrdata[18] == $past(o_timer_io_b);
  endproperty
  property p_wave_noload;
    s_read(8'h20) ##0 !o_timer_io_a_oen |=> o_hrdata[6:5] == 2'h0 && !o_hrdata[1];
  endproperty
  property p_capt_nomatch;
    s_read(8'h20) ##0 o_timer_io_a_oen |=> o_hrdata[3:2] == 2'h0;
  endproperty
  // irq is registered from the next mask, so it falls at the mask update edge; one spare edge allowed
  property p_irq_off;
    s_take(8'h28, 1'b1) ##1 i_hwdata[7:0] == 8'hFF |-> ##[1:2] !o_irq;
  endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("count high half set");
  a_cmp_hi: assert property (p_cmp_hi) else $error("compare high set");
  a_sr_hi: assert property (p_sr_hi) else $error("status spare bits set");
  a_mask_hi: assert property (p_mask_hi) else $error("mask spare bits");
  a_mir_a: assert property (p_mir_a) else $error("io a mirror wrong");
  a_mir_b: assert property (p_mir_b) else $error("io b mirror wrong");
  a_wave_noload: assert property (p_wave_noload) else $error("load flag");
  a_capt_nomatch: assert property (p_capt_nomatch) else $error("match flag");
  a_irq_off: assert property (p_irq_off) else $error("irq after disable");
endmodule
bind tc_channel tc_channel_sva u_sva (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .o_hrdata(o_hrdata), .o_timer_io_a(o_timer_io_a),
  .o_timer_io_a_oen(o_timer_io_a_oen), .o_timer_io_b(o_timer_io_b),
  .o_timer_io_b_oen(o_timer_io_b_oen), .o_irq(o_irq));

// ### verilog/tc_channel.sv
// Purpose: one timer channel: counter, capture/compare, status, irq
// Assumes: i_count_en is a one-cycle pulse per counter clock period
// Notes: AHB-Lite slave, zero wait states, always OKAY
`timescale 1ns/1ps
`include "tc_defs.svh"

// Contract
// - counter value register returns live count
// - capture regs ignore writes in capture mode
// - third compare register always read write
// - overflow flag set, cleared by status read
// - capture mode load overrun flag
// - waveform mode first and second match flags
// - third match flag in both modes
// - capture mode first and second load flags
// - external trigger flag, cleared by status read
// - status bit 16 shows count clock on
// - status bits 17, 18 mirror io lines
// - shared eight-bit event layout for all
// - enable register writes ones into mask
// - disable register writes ones clear mask
// - mask register reads enabled sources
// - mode bit: 0 capture, 1 waveform
// - capture loads on selected io_a edge
module tc_channel (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_count_en,
  input wire logic i_timer_io_a,
  output logic o_timer_io_a,
  output logic o_timer_io_a_oen,
  input wire logic i_timer_io_b,
  output logic o_timer_io_b,
  output logic o_timer_io_b_oen,
  output logic o_irq
);
  import tc_pkg::*;

  tc_state_s st_reg;
  tc_state_s st_next;

  logic a_level;
  logic a_rise;
  logic a_fall;
  logic b_level;
  logic b_rise;
  logic b_fall;
  flag_t flags;
  flag_t mask;
  logic irq;
  flag_t ev;
  logic rd_sr;
  logic en_wr;
  logic dis_wr;
  flag_t wr_low;

  // each pin is synchronised once; io_a edges feed loads and trigger, io_b edges feed the trigger only
  tc_pin_edge u_edge_a (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_pin(i_timer_io_a),
    .o_level(a_level),
    .o_rise(a_rise),
    .o_fall(a_fall)
  );

  tc_pin_edge u_edge_b (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_pin(i_timer_io_b),
    .o_level(b_level),
    .o_rise(b_rise),
    .o_fall(b_fall)
  );

  tc_irq_bank u_irq (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_set(ev),
    .i_clr(rd_sr),
    .i_en_wr(en_wr),
    .i_dis_wr(dis_wr),
    .i_wdata(wr_low),
    .o_flags(flags),
    .o_mask(mask),
    .o_irq(irq)
  );

  function automatic logic edge_hit(input edge_sel_t sel,
                                    input logic rise,
                                    input logic fall);
    logic hit;
    hit = 1'b0;
    case (sel)
      `EDGE_NONE: hit = 1'b0;
      `EDGE_RISE: hit = rise;
      `EDGE_FALL: hit = fall;
      `EDGE_BOTH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  always_comb begin
    logic wave;
    logic addr_ok;
    logic rd_ra;
    logic rd_rb;
    logic clken_w;
    logic clkdis_w;
    logic swtrg_w;
    logic trig_ev;
    logic tick;
    logic match_a;
    logic match_b;
    logic match_c;
    logic load_a;
    logic load_b;
    logic src_rise;
    logic src_fall;
    logic mir_a;
    logic mir_b;
    count_t cnt_inc;
    logic [31:0] rdata;

    st_next = st_reg;
    ev = '0;
    rd_sr = 1'b0;
    en_wr = 1'b0;
    dis_wr = 1'b0;
    wr_low = i_hwdata[7:0];
    rd_ra = 1'b0;
    rd_rb = 1'b0;
    clken_w = 1'b0;
    clkdis_w = 1'b0;
    swtrg_w = 1'b0;
    match_a = 1'b0;
    match_b = 1'b0;
    match_c = 1'b0;
    load_a = 1'b0;
    load_b = 1'b0;
    rdata = 32'h0000_0000;
    mir_a = 1'b0;
    mir_b = 1'b0;
    wave = st_reg.mode[`MODE_WAVE];
    addr_ok = i_hsel & i_htrans[1] & i_hready;
    cnt_inc = 16'(st_reg.cnt + 16'h0001);

    // write data phase: commit i_hwdata to the address latched in the address phase
    if (st_reg.wr_pend) begin
      case (st_reg.wr_addr)
        `TC_OFF_CTRL: begin
          clken_w = i_hwdata[`CTRL_CLKEN];
          clkdis_w = i_hwdata[`CTRL_CLKDIS];
          swtrg_w = i_hwdata[`CTRL_SWTRG];
        end
        `TC_OFF_MODE: st_next.mode = i_hwdata;
        `TC_OFF_RA: begin
          if (wave) begin
            st_next.ra = i_hwdata[15:0];
          end
        end
        `TC_OFF_RB: begin
          if (wave) begin
            st_next.rb = i_hwdata[15:0];
          end
        end
        `TC_OFF_RC: st_next.rc = i_hwdata[15:0];
        `TC_OFF_IER: en_wr = 1'b1;
        `TC_OFF_IDR: dis_wr = 1'b1;
        default: ;
      endcase
    end

    // external trigger from the selected line
    src_rise = st_reg.mode[`MODE_TRG_SRC_A] ? a_rise : b_rise;
    src_fall = st_reg.mode[`MODE_TRG_SRC_A] ? a_fall : b_fall;
    trig_ev = edge_hit(st_reg.mode[`MODE_TRG_EDGE_LO +: 2],
                       src_rise, src_fall);
    ev[`FLG_ETRG] = trig_ev;

    // counter engine
    tick = i_count_en & st_reg.clk_on;
    if (tick) begin
      st_next.cnt = cnt_inc;
      if (st_reg.cnt == `CNT_MAX) begin
        ev[`FLG_COVF] = 1'b1;
      end
      match_a = (cnt_inc == st_reg.ra);
      match_b = (cnt_inc == st_reg.rb);
      match_c = (cnt_inc == st_reg.rc);
    end
    ev[`FLG_CPC] = match_c;

    // a restart wins over counting; disable wins over enable
    if (swtrg_w | trig_ev | (match_c & st_reg.mode[`MODE_RC_TRG])) begin
      st_next.cnt = `CNT_RST;
    end
    if (clkdis_w) begin
      st_next.clk_on = 1'b0;
    end else if (clken_w | swtrg_w | trig_ev) begin
      st_next.clk_on = 1'b1;
    end

    // address phase: read data is captured at this edge
    if (addr_ok & ~i_hwrite) begin
      case (i_haddr[7:0])
        `TC_OFF_MODE: rdata = st_reg.mode;
        `TC_OFF_CV: rdata = {16'h0000, st_reg.cnt};
        `TC_OFF_RA: begin
          rdata = {16'h0000, st_reg.ra};
          rd_ra = 1'b1;
        end
        `TC_OFF_RB: begin
          rdata = {16'h0000, st_reg.rb};
          rd_rb = 1'b1;
        end
        `TC_OFF_RC: rdata = {16'h0000, st_reg.rc};
        `TC_OFF_SR: begin
          mir_a = wave ? st_reg.drv_a : a_level;
          mir_b = wave ? st_reg.drv_b : b_level;
          rdata = {13'h0000, mir_b, mir_a, st_reg.clk_on,
                   8'h00, flags};
          rd_sr = 1'b1;
        end
        `TC_OFF_IMR: rdata = {24'h00_0000, mask};
        default: rdata = 32'h0000_0000;
      endcase
      st_next.hrdata = rdata;
    end
    st_next.wr_pend = addr_ok & i_hwrite;
    st_next.wr_addr = i_haddr[7:0];
    st_next.hreadyout = 1'b1;

    // reading a capture register marks it consumed
    if (rd_ra) begin
      st_next.ra_unread = 1'b0;
    end
    if (rd_rb) begin
      st_next.rb_unread = 1'b0;
    end

    if (!wave) begin
      // capture mode: lines are inputs, loads take the count
      st_next.oen_a = 1'b1;
      st_next.oen_b = 1'b1;
      load_a = edge_hit(st_reg.mode[`MODE_LDRA_LO +: 2],
                        a_rise, a_fall);
      load_b = edge_hit(st_reg.mode[`MODE_LDRB_LO +: 2],
                        a_rise, a_fall);
      if (load_a) begin
        st_next.ra = st_reg.cnt;
        st_next.ra_unread = 1'b1;
        ev[`FLG_LDRA] = 1'b1;
      end
      if (load_b) begin
        st_next.rb = st_reg.cnt;
        st_next.rb_unread = 1'b1;
        ev[`FLG_LDRB] = 1'b1;
      end
      // a load onto a value nobody read is an overrun
      ev[`FLG_LOVR] = (load_a & st_reg.ra_unread)
                    | (load_b & st_reg.rb_unread);
    end else begin
      // waveform mode: drive both lines from the compares
      st_next.oen_a = 1'b0;
      st_next.oen_b = 1'b0;
      st_next.ra_unread = 1'b0;
      st_next.rb_unread = 1'b0;
      ev[`FLG_CPA] = match_a;
      ev[`FLG_CPB] = match_b;
      if (match_c) begin
        st_next.drv_a = 1'b0;
      end else if (match_a) begin
        st_next.drv_a = 1'b1;
      end
      if (match_b) begin
        st_next.drv_b = ~st_reg.drv_b;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st_reg.hrdata <= `HRDATA_RST;
      st_reg.hreadyout <= 1'b1;
      st_reg.wr_pend <= 1'b0;
      st_reg.wr_addr <= 8'h00;
      st_reg.mode <= `MODE_RST;
      st_reg.cnt <= `CNT_RST;
      st_reg.ra <= `CNT_RST;
      st_reg.rb <= `CNT_RST;
      st_reg.rc <= `CNT_RST;
      st_reg.clk_on <= 1'b0;
      st_reg.ra_unread <= 1'b0;
      st_reg.rb_unread <= 1'b0;
      st_reg.drv_a <= 1'b0;
      st_reg.drv_b <= 1'b0;
      st_reg.oen_a <= 1'b1;
      st_reg.oen_b <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_hrdata = st_reg.hrdata;
  assign o_hreadyout = st_reg.hreadyout;
  assign o_hresp = 1'b0;
  assign o_timer_io_a = st_reg.drv_a;
  assign o_timer_io_a_oen = st_reg.oen_a;
  assign o_timer_io_b = st_reg.drv_b;
  assign o_timer_io_b_oen = st_reg.oen_b;
  assign o_irq = irq;
endmodule

// ### verilog/tc_defs.svh
// Purpose: constants for the timer channel register block
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: offsets are byte addresses within the block
`ifndef TC_DEFS_SVH
`define TC_DEFS_SVH

`define TC_OFF_CTRL 8'h00
`define TC_OFF_MODE 8'h04
`define TC_OFF_CV 8'h10
`define TC_OFF_RA 8'h14
`define TC_OFF_RB 8'h18
`define TC_OFF_RC 8'h1C
`define TC_OFF_SR 8'h20
`define TC_OFF_IER 8'h24
`define TC_OFF_IDR 8'h28
`define TC_OFF_IMR 8'h2C

`define FLG_COVF 0
`define FLG_LOVR 1
`define FLG_CPA 2
`define FLG_CPB 3
`define FLG_CPC 4
`define FLG_LDRA 5
`define FLG_LDRB 6
`define FLG_ETRG 7

`define SR_COUNT_CLOCK_ON 16
`define SR_IO_A_MIRROR 17
`define SR_IO_B_MIRROR 18

`define CTRL_CLKEN 0
`define CTRL_CLKDIS 1
`define CTRL_SWTRG 2

`define MODE_TRG_EDGE_LO 8
`define MODE_TRG_SRC_A 10
`define MODE_RC_TRG 14
`define MODE_WAVE 15
`define MODE_LDRA_LO 16
`define MODE_LDRB_LO 18

`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

`define MODE_RST 32'h0000_0000
`define CNT_RST 16'h0000
`define CNT_MAX 16'hFFFF
`define FLAGS_RST 8'h00
`define MASK_RST 8'h00
`define HRDATA_RST 32'h0000_0000

`endif

// ### verilog/tc_irq_bank.sv
// Purpose: sticky event flags, interrupt mask and the interrupt level
// Assumes: i_clr is the one-cycle status read pulse
// Notes: a set in the clearing cycle survives the clear
`timescale 1ns/1ps
`include "tc_defs.svh"
module tc_irq_bank (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input tc_pkg::flag_t i_set,
  input wire logic i_clr,
  input wire logic i_en_wr,
  input wire logic i_dis_wr,
  input tc_pkg::flag_t i_wdata,
  output tc_pkg::flag_t o_flags,
  output tc_pkg::flag_t o_mask,
  output logic o_irq
);
  import tc_pkg::*;

  irq_state_s st_reg;
  irq_state_s st_next;

  always_comb begin
    st_next = st_reg;
    if (i_clr) begin
      st_next.flags = `FLAGS_RST;
    end
    st_next.flags = st_next.flags | i_set;
    if (i_en_wr) begin
      st_next.mask = st_next.mask | i_wdata;
    end
    if (i_dis_wr) begin
      st_next.mask = st_next.mask & ~i_wdata;
    end
    st_next.irq = |(st_next.flags & st_next.mask);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st_reg.flags <= `FLAGS_RST;
      st_reg.mask <= `MASK_RST;
      st_reg.irq <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_flags = st_reg.flags;
  assign o_mask = st_reg.mask;
  assign o_irq = st_reg.irq;
endmodule

// ### verilog/tc_pin_edge.sv
// Purpose: two-flop synchroniser with rise and fall pulses for one pin
// Assumes: pin is asynchronous to i_clk_sys
// Notes: edges come from the second and third flops only
`timescale 1ns/1ps
module tc_pin_edge (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  import tc_pkg::*;

  edge_state_s st_reg;
  edge_state_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = i_pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.s2;
  assign o_rise = st_reg.s2 & ~st_reg.s3;
  assign o_fall = ~st_reg.s2 & st_reg.s3;
endmodule

// ### verilog/tc_pkg.sv
// Purpose: types shared by the timer channel modules
// Assumes: constants come from tc_defs.svh
// Notes: each module keeps all of its state in one struct
package tc_pkg;

  typedef logic [15:0] count_t;
  typedef logic [7:0] flag_t;
  typedef logic [1:0] edge_sel_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } edge_state_s;

  typedef struct packed {
    flag_t flags;
    flag_t mask;
    logic irq;
  } irq_state_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] mode;
    count_t cnt;
    count_t ra;
    count_t rb;
    count_t rc;
    logic clk_on;
    logic ra_unread;
    logic rb_unread;
    logic drv_a;
    logic drv_b;
    logic oen_a;
    logic oen_b;
  } tc_state_s;

endpackage
